// file: logic/meter_frontend_params.svh
`ifndef METER_FRONTEND_PARAMS_SVH
`define METER_FRONTEND_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define MF_IDX_GAIN          8'h1b
`define MF_IDX_ZC            8'h2b
`define MF_IDX_CHSEL         8'h3d
`define MF_IDX_SIGNDIR       8'h0f
`define MF_IDX_STATUS        8'h40
`define MF_IDX_LSB           2

// Gain register fields.
`define MF_VGAIN_HI          7
`define MF_VGAIN_LO          5
`define MF_SIGNSRC_BIT       3
`define MF_IGAIN_HI          2
`define MF_IGAIN_LO          0
`define MF_GAIN_RESET        8'h00
`define MF_GAIN_CODE_MAX     3'h4

// Zero crossing output control fields.
`define MF_ZC_FIRST_BIT      1
`define MF_ZC_SECOND_BIT     0
`define MF_ZC_RESET          2'h0

// Current channel select fields.
`define MF_ISEL_HI           5
`define MF_ISEL_LO           4
`define MF_VGND_BIT          3
`define MF_IGND_BIT          2
`define MF_CHSEL_RESET       8'h00
`define MF_ISEL_FORCE_A      2'h1
`define MF_ISEL_FORCE_B      2'h2

// Sign event direction fields.
`define MF_REACT_DIR_BIT     5
`define MF_ACT_DIR_BIT       4
`define MF_SIGNDIR_RESET     2'h0

// Status register fields.
`define MF_ST_INPUT_B_BIT    0
`define MF_ST_ACT_NEG_BIT    1
`define MF_ST_REACT_NEG_BIT  2

`endif

// file: logic/meter_frontend_pkg.sv
package meter_frontend_pkg;

    typedef enum logic {
        BUS_WAIT   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_e;

    typedef logic [2:0] gain_code_t;
    typedef logic [4:0] gain_factor_t;
    typedef logic [1:0] input_sel_t;

endpackage

// file: logic/sign_change_detect.sv
module sign_change_detect
    import meter_frontend_pkg::*;
(
    // Clock and reset.
    input  wire logic clock,
    input  wire logic srst,
    // Sign inputs.
    input  wire logic power_negative,
    input  wire logic pulse_event,
    // Configuration.
    input  wire logic use_pulse,
    input  wire logic rising_dir,
    // Results.
    output logic      sign_event,
    output logic      sign_negative
);

    logic sampled_neg;
    logic event_d;

    // The sign follows the filtered power, or is taken only at pulse events.
    always_comb begin
        if (use_pulse) begin
            sampled_neg = pulse_event ? power_negative : sign_negative;
        end else begin
            sampled_neg = power_negative;
        end
    end

    always_comb begin
        event_d = 1'b0;
        if (sampled_neg != sign_negative) begin
            event_d = rising_dir ? ~sampled_neg : sampled_neg;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sign_negative <= 1'b0;
        end else begin
            sign_negative <= sampled_neg;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sign_event <= 1'b0;
        end else begin
            sign_event <= event_d;
        end
    end

endmodule

// file: logic/meter_frontend_config_regs.sv
`include "meter_frontend_params.svh"

module meter_frontend_config_regs
    import meter_frontend_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
)
(
    // Clock and reset.
    input  wire logic                  clock,
    input  wire logic                  srst,
    // APB slave.
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Input gain control.
    output gain_code_t                 voltage_gain_sel,
    output gain_factor_t               voltage_gain_factor,
    output gain_code_t                 current_gain_sel,
    output gain_factor_t               current_gain_factor,
    // Power sign detection.
    output logic                       sign_detect_source,
    input  wire logic                  active_power_negative,
    input  wire logic                  reactive_power_negative,
    input  wire logic                  energy_pulse_output,
    output logic                       active_sign_event,
    output logic                       reactive_sign_event,
    // Zero crossing port pins.
    input  wire logic                  zc_signal,
    output logic                       zc_first_pin_out,
    output logic                       zc_first_pin_oe_n,
    output logic                       zc_second_pin_out,
    output logic                       zc_second_pin_oe_n,
    // Current channel and grounding.
    input  wire logic                  tamper_select_b,
    output input_sel_t                 current_input_sel,
    output logic                       measure_input_b,
    output logic                       voltage_input_ground,
    output logic                       current_input_ground
);

    localparam int INDEX_WIDTH = 8;

    // The address must hold the byte offset and the whole word index;
    // narrower buses, or buses wider than 32 bits, are refused at elaboration.
    if (ADDR_WIDTH < INDEX_WIDTH + `MF_IDX_LSB || ADDR_WIDTH > 32) begin : g_addr_width_check
        $error("meter_frontend_config_regs: ADDR_WIDTH out of range");
    end

    // Register state.
    logic [7:0]   gain_q;
    logic [1:0]   zc_ctrl_q;
    logic [7:0]   chsel_q;
    logic [1:0]   signdir_q;
    bus_state_e   bus_q;
    logic [31:0]  rdata_d;
    logic         err_d;
    gain_factor_t vfactor_d;
    gain_factor_t ifactor_d;
    logic         input_b_d;
    logic         act_neg;
    logic         react_neg;

    logic [INDEX_WIDTH-1:0] index;
    logic                   aligned;
    logic                   high_zero;
    logic                   hit_gain;
    logic                   hit_zc;
    logic                   hit_chsel;
    logic                   hit_signdir;
    logic                   hit_status;
    logic                   mapped;
    logic                   wr_commit;

    // Address decode; only whole aligned words inside the index range are mapped.
    assign index     = paddr[`MF_IDX_LSB +: INDEX_WIDTH];
    assign aligned   = (paddr[`MF_IDX_LSB-1:0] == '0);
    assign high_zero = (ADDR_WIDTH == INDEX_WIDTH + `MF_IDX_LSB) ? 1'b1 :
                       ((paddr >> (INDEX_WIDTH + `MF_IDX_LSB)) == '0);

    assign hit_gain    = aligned && high_zero && (index == `MF_IDX_GAIN);
    assign hit_zc      = aligned && high_zero && (index == `MF_IDX_ZC);
    assign hit_chsel   = aligned && high_zero && (index == `MF_IDX_CHSEL);
    assign hit_signdir = aligned && high_zero && (index == `MF_IDX_SIGNDIR);
    assign hit_status  = aligned && high_zero && (index == `MF_IDX_STATUS);
    assign mapped      = hit_gain || hit_zc || hit_chsel || hit_signdir || hit_status;

    // A write lands at the edge where the master sees pready high.
    assign wr_commit = psel && penable && pready && pwrite && mapped && pstrb[0];

    // Bus answer: one wait cycle, then pready stands for one cycle.
    always_ff @(posedge clock) begin
        if (srst) begin
            bus_q <= BUS_WAIT;
        end else begin
            unique case (bus_q)
                BUS_WAIT: begin
                    if (psel && penable) begin
                        bus_q <= BUS_ANSWER;
                    end
                end
                BUS_ANSWER: begin
                    bus_q <= BUS_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= (bus_q == BUS_WAIT) && psel && penable;
        end
    end

    // Read data mux; unused bits read as zero, except channel select bits 7:6 and 1:0, which read back as written.
    always_comb begin
        rdata_d = '0;
        if (hit_gain) begin
            rdata_d[7:0] = gain_q;
        end
        if (hit_zc) begin
            rdata_d[`MF_ZC_FIRST_BIT]  = zc_ctrl_q[`MF_ZC_FIRST_BIT];
            rdata_d[`MF_ZC_SECOND_BIT] = zc_ctrl_q[`MF_ZC_SECOND_BIT];
        end
        if (hit_chsel) begin
            rdata_d[7:0] = chsel_q;
        end
        if (hit_signdir) begin
            rdata_d[`MF_ACT_DIR_BIT]   = signdir_q[0];
            rdata_d[`MF_REACT_DIR_BIT] = signdir_q[1];
        end
        if (hit_status) begin
            rdata_d[`MF_ST_INPUT_B_BIT]   = measure_input_b;
            rdata_d[`MF_ST_ACT_NEG_BIT]   = act_neg;
            rdata_d[`MF_ST_REACT_NEG_BIT] = react_neg;
        end
    end

    // Unmapped addresses and writes to the status word answer with an error.
    assign err_d = !mapped || (pwrite && hit_status);

    always_ff @(posedge clock) begin
        if (srst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if ((bus_q == BUS_WAIT) && psel && penable) begin
            prdata  <= pwrite ? '0 : rdata_d;
            pslverr <= err_d;
        end else begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

    // Gain register; the reserved bit 4 is never stored.
    always_ff @(posedge clock) begin
        if (srst) begin
            gain_q <= `MF_GAIN_RESET;
        end else if (wr_commit && hit_gain) begin
            gain_q[`MF_VGAIN_HI:`MF_VGAIN_LO] <= pwdata[`MF_VGAIN_HI:`MF_VGAIN_LO];
            gain_q[`MF_SIGNSRC_BIT]           <= pwdata[`MF_SIGNSRC_BIT];
            gain_q[`MF_IGAIN_HI:`MF_IGAIN_LO] <= pwdata[`MF_IGAIN_HI:`MF_IGAIN_LO];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            zc_ctrl_q <= `MF_ZC_RESET;
        end else if (wr_commit && hit_zc) begin
            zc_ctrl_q[`MF_ZC_FIRST_BIT]  <= pwdata[`MF_ZC_FIRST_BIT];
            zc_ctrl_q[`MF_ZC_SECOND_BIT] <= pwdata[`MF_ZC_SECOND_BIT];
        end
    end

    // Bits 7:6 and 1:0 are stored as written; software must keep them clear.
    always_ff @(posedge clock) begin
        if (srst) begin
            chsel_q <= `MF_CHSEL_RESET;
        end else if (wr_commit && hit_chsel) begin
            chsel_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            signdir_q <= `MF_SIGNDIR_RESET;
        end else if (wr_commit && hit_signdir) begin
            signdir_q[0] <= pwdata[`MF_ACT_DIR_BIT];
            signdir_q[1] <= pwdata[`MF_REACT_DIR_BIT];
        end
    end

    // Gain codes above the largest defined one give a factor of zero.
    function automatic gain_factor_t gain_factor(input gain_code_t code);
        gain_factor_t factor;
        factor = '0;
        if (code <= `MF_GAIN_CODE_MAX) begin
            factor = gain_factor_t'(5'h01 << code);
        end
        return factor;
    endfunction

    assign vfactor_d = gain_factor(gain_q[`MF_VGAIN_HI:`MF_VGAIN_LO]);
    assign ifactor_d = gain_factor(gain_q[`MF_IGAIN_HI:`MF_IGAIN_LO]);

    always_ff @(posedge clock) begin
        if (srst) begin
            voltage_gain_sel    <= '0;
            voltage_gain_factor <= '0;
            current_gain_sel    <= '0;
            current_gain_factor <= '0;
        end else begin
            voltage_gain_sel    <= gain_q[`MF_VGAIN_HI:`MF_VGAIN_LO];
            voltage_gain_factor <= vfactor_d;
            current_gain_sel    <= gain_q[`MF_IGAIN_HI:`MF_IGAIN_LO];
            current_gain_factor <= ifactor_d;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sign_detect_source <= 1'b0;
        end else begin
            sign_detect_source <= gain_q[`MF_SIGNSRC_BIT];
        end
    end

    // Sign change detection for active and reactive power.
    sign_change_detect active_detect (
        .clock          (clock),
        .srst           (srst),
        .power_negative (active_power_negative),
        .pulse_event    (energy_pulse_output),
        .use_pulse      (gain_q[`MF_SIGNSRC_BIT]),
        .rising_dir     (signdir_q[0]),
        .sign_event     (active_sign_event),
        .sign_negative  (act_neg)
    );

    sign_change_detect reactive_detect (
        .clock          (clock),
        .srst           (srst),
        .power_negative (reactive_power_negative),
        .pulse_event    (energy_pulse_output),
        .use_pulse      (gain_q[`MF_SIGNSRC_BIT]),
        .rising_dir     (signdir_q[1]),
        .sign_event     (reactive_sign_event),
        .sign_negative  (react_neg)
    );

    // Zero crossing pins; a disabled pin drives low and releases its enable.
    always_ff @(posedge clock) begin
        if (srst) begin
            zc_first_pin_out   <= 1'b0;
            zc_first_pin_oe_n  <= 1'b1;
            zc_second_pin_out  <= 1'b0;
            zc_second_pin_oe_n <= 1'b1;
        end else begin
            zc_first_pin_out   <= zc_ctrl_q[`MF_ZC_FIRST_BIT] & zc_signal;
            zc_first_pin_oe_n  <= ~zc_ctrl_q[`MF_ZC_FIRST_BIT];
            zc_second_pin_out  <= zc_ctrl_q[`MF_ZC_SECOND_BIT] & zc_signal;
            zc_second_pin_oe_n <= ~zc_ctrl_q[`MF_ZC_SECOND_BIT];
        end
    end

    // Current channel choice.
    always_comb begin
        unique case (chsel_q[`MF_ISEL_HI:`MF_ISEL_LO])
            `MF_ISEL_FORCE_A: input_b_d = 1'b0;
            `MF_ISEL_FORCE_B: input_b_d = 1'b1;
            default:          input_b_d = tamper_select_b;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            current_input_sel <= '0;
            measure_input_b   <= 1'b0;
        end else begin
            current_input_sel <= chsel_q[`MF_ISEL_HI:`MF_ISEL_LO];
            measure_input_b   <= input_b_d;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            voltage_input_ground <= 1'b0;
            current_input_ground <= 1'b0;
        end else begin
            voltage_input_ground <= chsel_q[`MF_VGND_BIT];
            current_input_ground <= chsel_q[`MF_IGND_BIT];
        end
    end

endmodule

// file: bench/meter_frontend_config_regs_asserts.sv
module meter_frontend_config_regs_asserts
    import meter_frontend_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
)
(
    // Clock, reset and bus.
    input wire logic                  clock,
    input wire logic                  srst,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Block outputs and inputs.
    input wire gain_code_t            voltage_gain_sel,
    input wire gain_factor_t          voltage_gain_factor,
    input wire gain_code_t            current_gain_sel,
    input wire gain_factor_t          current_gain_factor,
    input wire logic                  sign_detect_source,
    input wire logic                  zc_signal,
    input wire logic                  zc_first_pin_out,
    input wire logic                  zc_first_pin_oe_n,
    input wire logic                  zc_second_pin_out,
    input wire logic                  zc_second_pin_oe_n,
    input wire logic                  tamper_select_b,
    input wire input_sel_t            current_input_sel,
    input wire logic                  measure_input_b,
    input wire logic                  voltage_input_ground,
    input wire logic                  current_input_ground
);
    logic wr;
    assign wr = psel && penable && pready && pwrite && pstrb[0];

    function automatic gain_factor_t fac(input gain_code_t c);
        return (c <= 3'h4) ? gain_factor_t'(5'h1 << c) : 5'h00;
    endfunction

    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);

    AST_VGAIN_SRC: assert property (wr && paddr == 12'h06c |-> ##2
        voltage_gain_sel == $past(pwdata[7:5], 2) && voltage_gain_factor == fac($past(pwdata[7:5], 2))
        && sign_detect_source == $past(pwdata[3], 2)) else $error("voltage gain or source mismatch");
    AST_IGAIN: assert property (wr && paddr == 12'h06c |-> ##2
        current_gain_sel == $past(pwdata[2:0], 2) && current_gain_factor == fac($past(pwdata[2:0], 2)))
        else $error("current gain mismatch");
    AST_ZC_EN: assert property (wr && paddr == 12'h0ac |-> ##2
        zc_first_pin_oe_n == !$past(pwdata[1], 2) && zc_second_pin_oe_n == !$past(pwdata[0], 2))
        else $error("zero crossing enable mismatch");
    AST_ZC_OUT1: assert property (!zc_first_pin_oe_n && !$past(zc_first_pin_oe_n) |->
        zc_first_pin_out == $past(zc_signal)) else $error("first pin does not follow zero crossing");
    AST_ZC_OUT2: assert property (!zc_second_pin_oe_n && !$past(zc_second_pin_oe_n) |->
        zc_second_pin_out == $past(zc_signal)) else $error("second pin does not follow zero crossing");
    AST_CHSEL: assert property (wr && paddr == 12'h0f4 |-> ##2
        current_input_sel == $past(pwdata[5:4], 2) && voltage_input_ground == $past(pwdata[3], 2)
        && current_input_ground == $past(pwdata[2], 2)) else $error("channel select mismatch");
    AST_FORCE_B: assert property (current_input_sel == 2'h2 && $past(current_input_sel) == 2'h2 |->
        measure_input_b) else $error("input b not forced");
    AST_AUTO: assert property (!$past(srst) && !$past(srst, 2) && current_input_sel[1] == current_input_sel[0]
        && $past(current_input_sel) == current_input_sel && $stable(tamper_select_b)
        && $past(tamper_select_b, 2) == tamper_select_b |-> measure_input_b == tamper_select_b)
        else $error("automatic selection mismatch");
    AST_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready ##1 !pready)
        else $error("bus answer timing wrong");

    cover property (wr && paddr == 12'h06c);
    cover property (measure_input_b && current_input_sel == 2'h2);
    cover property (pready && pslverr);
endmodule

bind meter_frontend_config_regs meter_frontend_config_regs_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) chk (
    .clock, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pready, .pslverr,
    .voltage_gain_sel, .voltage_gain_factor, .current_gain_sel, .current_gain_factor, .sign_detect_source,
    .zc_signal, .zc_first_pin_out, .zc_first_pin_oe_n, .zc_second_pin_out, .zc_second_pin_oe_n,
    .tamper_select_b, .current_input_sel, .measure_input_b, .voltage_input_ground, .current_input_ground
);

// file: bench/meter_frontend_config_regs_test.sv
module meter_frontend_config_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import meter_frontend_pkg::*;

    logic         clock = 1'b0, srst = 1'b1;
    logic [11:0]  paddr = 12'h000;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]  pwdata = 32'h0, prdata;
    logic [3:0]   pstrb = 4'h0;
    logic         pready, pslverr, sign_detect_source, active_sign_event, reactive_sign_event;
    logic         active_power_negative = 1'b0, reactive_power_negative = 1'b0, energy_pulse_output = 1'b0;
    logic         zc_signal = 1'b0, tamper_select_b = 1'b0;
    logic         zc_first_pin_out, zc_first_pin_oe_n, zc_second_pin_out, zc_second_pin_oe_n;
    logic         measure_input_b, voltage_input_ground, current_input_ground;
    gain_code_t   voltage_gain_sel, current_gain_sel;
    gain_factor_t voltage_gain_factor, current_gain_factor;
    input_sel_t   current_input_sel;
    logic [33:0]  notes[$];
    logic [33:0]  note;
    int           errors = 0, cmp_count = 0, ev_a = 0, ev_r = 0;

    always #5 clock = ~clock;

    meter_frontend_config_regs #(.ADDR_WIDTH(12)) uut (
        .clock, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .voltage_gain_sel, .voltage_gain_factor, .current_gain_sel, .current_gain_factor, .sign_detect_source,
        .active_power_negative, .reactive_power_negative, .energy_pulse_output, .active_sign_event,
        .reactive_sign_event, .zc_signal, .zc_first_pin_out, .zc_first_pin_oe_n, .zc_second_pin_out,
        .zc_second_pin_oe_n, .tamper_select_b, .current_input_sel, .measure_input_b, .voltage_input_ground,
        .current_input_ground
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One APB transfer; the expected answer is queued for the monitor.
    task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] s,
                        input logic [7:0] e, input logic er);
        int n;
        n = 0;
        @(posedge clock);
        notes.push_back({w, er, 24'h0, e});
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h0, d};
        pstrb   <= s;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            print_verdict();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d, 4'hf, 8'h00, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00, 4'hf, e, 1'b0);
    endtask

    task automatic sign_step(input logic n, input logic e);
        ev_a = 0;
        ev_r = 0;
        active_power_negative   <= n;
        reactive_power_negative <= n;
        idle(6);
        check(ev_a, e);
        check(ev_r, e);
    endtask

    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            if (!note[33]) check(prdata, note[31:0]);
            check(pslverr, note[32]);
        end
        if (active_sign_event === 1'b1) ev_a++;
        if (reactive_sign_event === 1'b1) ev_r++;
    end

    initial begin
        idle(5000);
        errors++;
        print_verdict();
    end

    initial begin
        logic [2:0] c;
        logic       b, z, t, mb;
        logic [1:0] s, gd;
        void'($urandom(32'habc2));
        idle(4);
        srst <= 1'b0;
        idle(3);
        check(voltage_gain_factor, 32'h1);
        check(current_gain_factor, 32'h1);
        check({zc_first_pin_oe_n, zc_second_pin_oe_n}, 32'h3);
        rd(12'h06c, 8'h00);
        rd(12'h0ac, 8'h00);
        rd(12'h0f4, 8'h00);
        $display("test defaults done");
        for (int k = 0; k < 5; k++) begin
            c = 3'(1 + $urandom % 4);
            b = 1'($urandom);
            wr(12'h06c, {k[2:0], 1'b1, b, c});
            rd(12'h06c, {k[2:0], 1'b0, b, c});
            check(voltage_gain_sel, k);
            check(voltage_gain_factor, 32'h1 << k);
            check(current_gain_sel, c);
            check(current_gain_factor, 32'h1 << c);
            check(sign_detect_source, b);
        end
        xfer(12'h06c, 1'b1, 8'hff, 4'h0, 8'h00, 1'b0);
        rd(12'h06c, {3'h4, 1'b0, b, c});
        xfer(12'h100, 1'b1, 8'hff, 4'hf, 8'h00, 1'b1);
        xfer(12'h004, 1'b0, 8'h00, 4'hf, 8'h00, 1'b1);
        $display("test gains done");
        for (int m = 0; m < 4; m++) begin
            z = 1'($urandom);
            zc_signal <= z;
            wr(12'h0ac, {6'h3f, m[1:0]});
            rd(12'h0ac, {6'h00, m[1:0]});
            check(zc_first_pin_oe_n, !m[1]);
            check(zc_first_pin_out, m[1] & z);
            check(zc_second_pin_oe_n, !m[0]);
            check(zc_second_pin_out, m[0] & z);
        end
        $display("test zero crossing done");
        for (int k = 0; k < 8; k++) begin
            s = k[2:1];
            t = k[0];
            gd = 2'($urandom);
            tamper_select_b <= t;
            wr(12'h0f4, {2'b00, s, gd, 2'b00});
            rd(12'h0f4, {2'b00, s, gd, 2'b00});
            mb = (s == 2'h1) ? 1'b0 : (s == 2'h2) ? 1'b1 : t;
            rd(12'h100, {7'h00, mb});
            check(current_input_sel, s);
            check(measure_input_b, mb);
            check(voltage_input_ground, gd[1]);
            check(current_input_ground, gd[0]);
        end
        $display("test channel select done");
        wr(12'h06c, 8'h00);
        for (int d = 1; d >= 0; d--) begin
            wr(12'h03c, {2'b00, d[0], d[0], 4'h0});
            sign_step(1'b1, d == 0);
            sign_step(1'b0, d == 1);
        end
        wr(12'h06c, 8'h08);
        sign_step(1'b1, 1'b0);
        ev_a = 0;
        ev_r = 0;
        energy_pulse_output <= 1'b1;
        idle(1);
        energy_pulse_output <= 1'b0;
        idle(6);
        check(ev_a, 32'h1);
        check(ev_r, 32'h1);
        $display("test sign events done");
        print_verdict();
    end
endmodule
